// >>> core/reset_cause_recorder.sv
// Reset and wake cause recorder with restart program counter choice
`timescale 1ns/1ps
// Function
// - Every reset event updates cause flags in the status register, the power control register or both.
// - Power-on loads 0000h, clears stack and power-on flags, keeps brown-out, sets the rest.
// - Brown-out loads 0000h, clears brown-out and stack flags, keeps power-on, sets the rest.
// - Clear pin while running loads 0000h and clears the pin-clear flag only.
// - Clear pin asleep loads 0000h, clears pin-clear and power-down, sets timeout.
// - Watchdog reset while running loads 0000h and clears the timeout flag.
// - Watchdog in sleep wakes at sleep address plus one, clearing timeout and power-down.
// - Interrupt wake sets timeout, clears power-down, resumes at sleep address plus one.
// - With interrupts enabled, after that instruction push return and jump 0004h.
// - Reset instruction loads 0000h and clears the reset-instruction flag only.
// - Enabled stack overflow loads 0000h and sets the overflow flag.
// - Enabled stack underflow loads 0000h and sets the underflow flag.
// - Unimplemented flag positions read as zero.
// - Sleep with an interrupt pending is a no-op and leaves power-down unchanged.
module reset_cause_recorder
  import rcr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  input  wire logic            ce,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Reset and wake sources
  input  wire logic            por_event,
  input  wire logic            bor_event,
  input  wire logic            external_clear_pin_n,
  input  wire logic            watchdog_timer_expired,
  input  wire logic            interrupt_pending,
  input  wire logic            sleep_instr,
  input  wire logic            reset_instr,
  input  wire logic            stack_overflow,
  input  wire logic            stack_underflow,
  input  wire logic [PC_W-1:0] current_pc,
  // Core steering
  output logic                 pc_load,
  output logic [PC_W-1:0]      pc_value,
  output logic                 stack_push,
  output logic [PC_W-1:0]      push_addr,
  output logic                 asleep,
  output logic [3:0]           last_cause
);
  flag_bank_if status_fb ();
  flag_bank_if power_control_register_fb ();

  run_state_t      state_q, state_d;
  cause_t          cause_d, cause_q;
  logic            pin_prev_q;
  logic [7:0]      ctrl_q;
  logic [PC_W-1:0] sleep_pc_q;
  logic            pc_load_q, stack_push_q;
  logic [PC_W-1:0] pc_value_q, push_addr_q;
  logic [3:0]      rd_sel;
  logic            wr_status, wr_power_control_register, wr_ctrl;
  logic [31:0]     masks;

  // Per-cause masks: {power_control_register set, power_control_register clear, status set, status clear}
  function automatic logic [31:0] cause_masks(input cause_t c);
    logic [7:0] ps, pc, ss, sc;
    ps = 8'h00;
    pc = 8'h00;
    ss = 8'h00;
    sc = 8'h00;
    case (c)
      C_POR: begin
        ps = 8'h0c;
        pc = 8'hc2;
        ss = 8'h18;
      end
      C_BOR: begin
        ps = 8'h0c;
        pc = 8'hc1;
        ss = 8'h18;
      end
      C_PIN_RUN: begin
        pc = 8'h08;
      end
      C_PIN_SLEEP: begin
        pc = 8'h08;
        ss = 8'h10;
        sc = 8'h08;
      end
      C_WDT_RUN: begin
        sc = 8'h10;
      end
      C_WDT_WAKE: begin
        sc = 8'h18;
      end
      C_INT_WAKE: begin
        ss = 8'h10;
        sc = 8'h08;
      end
      C_RESET_INSTR: begin
        pc = 8'h04;
      end
      C_OVF: begin
        ps = 8'h80;
      end
      C_UNF: begin
        ps = 8'h40;
      end
      default: begin
        ps = 8'h00;
      end
    endcase
    cause_masks = {ps, pc, ss, sc};
  endfunction

  function automatic logic is_restart(input cause_t c);
    is_restart = (c != C_NONE) && (c != C_WDT_WAKE) && (c != C_INT_WAKE);
  endfunction

  wire in_sleep   = (state_q == ST_SLEEP);
  wire pin_fall   = pin_prev_q & ~external_clear_pin_n;
  wire stk_en     = ctrl_q[STKEN_BIT];
  wire global_interrupt_enable        = ctrl_q[GIE_BIT];

  assign cause_d = por_event              ? C_POR :
                   bor_event              ? C_BOR :
                   pin_fall               ? (in_sleep ? C_PIN_SLEEP : C_PIN_RUN) :
                   watchdog_timer_expired ? (in_sleep ? C_WDT_WAKE : C_WDT_RUN) :
                   (in_sleep & interrupt_pending) ? C_INT_WAKE :
                   reset_instr            ? C_RESET_INSTR :
                   (stack_overflow & stk_en)  ? C_OVF :
                   (stack_underflow & stk_en) ? C_UNF : C_NONE;

  // sleep only entered with no interrupt pending
  wire sleep_go  = (state_q == ST_RUN) & (cause_d == C_NONE) & sleep_instr & ~interrupt_pending;
  wire restart   = is_restart(cause_d);
  wire wake      = (cause_d == C_WDT_WAKE) | (cause_d == C_INT_WAKE);
  // vector only after an interrupt wake with interrupts enabled
  wire vec_go    = (state_q == ST_STEP) & (cause_d == C_NONE);

  assign masks = cause_masks(cause_d);

  // power-on and brown-out share the flag bank write path
  assign power_control_register_fb.ce         = ce;
  assign power_control_register_fb.sw_we      = wr_power_control_register;
  assign power_control_register_fb.sw_data    = pwdata[7:0];
  assign power_control_register_fb.set_mask   = masks[31:24];
  assign power_control_register_fb.clr_mask   = masks[23:16];
  assign status_fb.ce       = ce;
  assign status_fb.sw_we    = wr_status;
  assign status_fb.sw_data  = pwdata[7:0];
  assign status_fb.set_mask = masks[15:8] | (sleep_go ? 8'h10 : 8'h00);
  assign status_fb.clr_mask = masks[7:0] | (sleep_go ? 8'h08 : 8'h00);

  cause_flag_bank #(
    .RST_VAL (STATUS_RST),
    .IMPL    (STATUS_IMPL),
    .SW_MASK (STATUS_SW)
  ) u_status (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .fb       (status_fb.bank)
  );

  // unimplemented positions masked to zero in the bank
  cause_flag_bank #(
    .RST_VAL (POWER_CONTROL_REGISTER_RST),
    .IMPL    (POWER_CONTROL_REGISTER_IMPL),
    .SW_MASK (POWER_CONTROL_REGISTER_SW)
  ) u_power_control_register (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .fb       (power_control_register_fb.bank)
  );

  cause_apb_decode u_dec (
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .ce        (ce),
    .rd_sel    (rd_sel),
    .wr_status (wr_status),
    .wr_power_control_register   (wr_power_control_register),
    .wr_ctrl   (wr_ctrl),
    .pready    (pready),
    .pslverr   (pslverr)
  );

  // read mux, upper bytes always zero
  wire [7:0] rd_byte = ({8{rd_sel[0]}} & status_fb.q) |
                       ({8{rd_sel[1]}} & power_control_register_fb.q) |
                       ({8{rd_sel[2]}} & ctrl_q) |
                       ({8{rd_sel[3]}} & {2'b00, state_q, cause_q});
  assign prdata = {24'h000000, rd_byte};

  // Any reset or wake cancels a pending step toward the vector
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (sleep_go) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (restart || cause_d == C_WDT_WAKE) begin
          state_d = ST_RUN;
        end else if (cause_d == C_INT_WAKE) begin
          state_d = global_interrupt_enable ? ST_STEP : ST_RUN;
        end
      end
      ST_STEP: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // wake resumes at sleep address plus one
  wire [PC_W-1:0] resume_pc = sleep_pc_q + 15'h0001;
  wire [PC_W-1:0] return_pc = sleep_pc_q + 15'h0002;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= ST_RUN;
      cause_q    <= C_POR;
      pin_prev_q <= 1'b1;
      ctrl_q     <= CTRL_RST;
      sleep_pc_q <= RESET_VEC;
    end else if (ce) begin
      state_q    <= state_d;
      pin_prev_q <= external_clear_pin_n;
      if (cause_d != C_NONE) begin
        cause_q <= cause_d;
      end
      if (wr_ctrl) begin
        ctrl_q <= pwdata[7:0] & 8'h03;
      end
      if (sleep_go) begin
        sleep_pc_q <= current_pc;
      end
    end
  end

  // resets steer the counter to the reset vector
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_load_q    <= 1'b0;
      pc_value_q   <= RESET_VEC;
      stack_push_q <= 1'b0;
      push_addr_q  <= RESET_VEC;
    end else if (ce) begin
      pc_load_q    <= restart | wake | (vec_go & ~restart);
      pc_value_q   <= restart ? RESET_VEC : (wake ? resume_pc : INT_VEC);
      stack_push_q <= vec_go & ~restart;
      push_addr_q  <= return_pc;
    end
  end

  assign pc_load    = pc_load_q;
  assign pc_value   = pc_value_q;
  assign stack_push = stack_push_q;
  assign push_addr  = push_addr_q;
  assign asleep     = (state_q == ST_SLEEP);
  assign last_cause = cause_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_por_flags: assert property (
    (ce && cause_d == C_POR) |=> (power_control_register_fb.q[7:1] == 7'b0000110) && status_fb.q[4:3] == 2'b11
  ) else $error("power-on flags wrong");

  a_bor_flags: assert property (
    (ce && cause_d == C_BOR && !wr_power_control_register) |=> power_control_register_fb.q[BOR_BIT] == 1'b0 &&
      power_control_register_fb.q[7:6] == 2'b00 &&
      power_control_register_fb.q[3:2] == 2'b11 && power_control_register_fb.q[POR_BIT] == $past(power_control_register_fb.q[POR_BIT])
  ) else $error("brown-out flags wrong");

  a_pin_sleep: assert property (
    (ce && cause_d == C_PIN_SLEEP) |=> !power_control_register_fb.q[PIN_CLEAR_FLAG_N_BIT] && status_fb.q[4:3] == 2'b10 &&
      pc_load && pc_value == RESET_VEC && !asleep
  ) else $error("clear pin in sleep wrong");

  a_wdt_run: assert property (
    (ce && cause_d == C_WDT_RUN) |=> !status_fb.q[TO_BIT] &&
      status_fb.q[PD_BIT] == $past(status_fb.q[PD_BIT]) && pc_load && pc_value == RESET_VEC
  ) else $error("watchdog reset wrong");

  a_wdt_wake: assert property (
    (ce && cause_d == C_WDT_WAKE) |=> pc_load && pc_value == $past(sleep_pc_q) + 15'h0001 &&
      status_fb.q[4:3] == 2'b00
  ) else $error("watchdog wake wrong");

  a_int_vector: assert property (
    (ce && cause_d == C_INT_WAKE && global_interrupt_enable) ##1 (ce && cause_d == C_NONE) |=>
      pc_load && stack_push && pc_value == INT_VEC
  ) else $error("interrupt vector not taken");

  a_int_wake: assert property (
    (ce && cause_d == C_INT_WAKE) |=> status_fb.q[4:3] == 2'b10 && pc_load &&
      pc_value == $past(sleep_pc_q) + 15'h0001 && !stack_push
  ) else $error("interrupt wake wrong");

  a_reset_instr: assert property (
    (ce && cause_d == C_RESET_INSTR && !wr_power_control_register) |=> !power_control_register_fb.q[RI_BIT] && pc_load &&
      power_control_register_fb.q[PIN_CLEAR_FLAG_N_BIT] == $past(power_control_register_fb.q[PIN_CLEAR_FLAG_N_BIT])
  ) else $error("reset instruction wrong");

  a_stack_flags: assert property (
    (ce && cause_d == C_OVF) |=> pc_load && pc_value == RESET_VEC && power_control_register_fb.q[OVF_BIT]
  ) else $error("stack overflow reset wrong");

  a_unf_flag: assert property (
    (ce && cause_d == C_UNF) |=> pc_load && pc_value == RESET_VEC && power_control_register_fb.q[UNF_BIT]
  ) else $error("stack underflow reset wrong");

  a_unimpl_zero: assert property (
    power_control_register_fb.q[5:4] == 2'b00 && status_fb.q[7:5] == 3'b000
  ) else $error("unimplemented bit not zero");

  a_sleep_nop: assert property (
    (ce && state_q == ST_RUN && cause_d == C_NONE && sleep_instr && interrupt_pending) |=>
      status_fb.q[PD_BIT] == $past(status_fb.q[PD_BIT]) && !asleep
  ) else $error("sleep not a no-op");

  c_sleep_wdt: cover property (sleep_go ##[1:50] (ce && cause_d == C_WDT_WAKE));
  c_int_vec: cover property (ce && stack_push);
  c_por_seen: cover property (ce && cause_d == C_POR);
  c_sw_race: cover property (wr_power_control_register && cause_d == C_PIN_RUN);
endmodule // reset_cause_recorder

// >>> include/rcr_pkg.sv
// Constants and types shared by the reset cause recorder
package rcr_pkg;

  // Register byte offsets on the APB window
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_POWER_CONTROL_REGISTER   = 12'h004;
  localparam logic [11:0] OFF_CTRL   = 12'h008;
  localparam logic [11:0] OFF_STATE  = 12'h00c;

  // Values after reset and implemented bit masks
  localparam logic [7:0] STATUS_RST  = 8'h18;
  localparam logic [7:0] STATUS_IMPL = 8'h1f;
  localparam logic [7:0] STATUS_SW   = 8'h07;
  localparam logic [7:0] POWER_CONTROL_REGISTER_RST    = 8'h0c;
  localparam logic [7:0] POWER_CONTROL_REGISTER_IMPL   = 8'hcf;
  localparam logic [7:0] POWER_CONTROL_REGISTER_SW     = 8'hcf;
  localparam logic [7:0] CTRL_RST    = 8'h00;

  // Field positions
  localparam int TO_BIT    = 4;
  localparam int PD_BIT    = 3;
  localparam int OVF_BIT   = 7;
  localparam int UNF_BIT   = 6;
  localparam int PIN_CLEAR_FLAG_N_BIT = 3;
  localparam int RI_BIT    = 2;
  localparam int POR_BIT   = 1;
  localparam int BOR_BIT   = 0;
  localparam int STKEN_BIT = 0;
  localparam int GIE_BIT   = 1;

  // Program counter width and vectors
  localparam int          PC_W      = 15;
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] INT_VEC   = 15'h0004;

  typedef enum logic [3:0] {
    C_NONE        = 4'h0,
    C_POR         = 4'h1,
    C_BOR         = 4'h2,
    C_PIN_RUN     = 4'h3,
    C_PIN_SLEEP   = 4'h4,
    C_WDT_RUN     = 4'h5,
    C_WDT_WAKE    = 4'h6,
    C_INT_WAKE    = 4'h7,
    C_RESET_INSTR = 4'h8,
    C_OVF         = 4'h9,
    C_UNF         = 4'ha
  } cause_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_STEP  = 2'b10
  } run_state_t;

endpackage

// >>> include/flag_bank_if.sv
// Carrier between the recorder and one flag register
`timescale 1ns/1ps
interface flag_bank_if;
  logic       ce;
  logic       sw_we;
  logic [7:0] sw_data;
  logic [7:0] set_mask;
  logic [7:0] clr_mask;
  logic [7:0] q;
  modport ctrl (output ce, sw_we, sw_data, set_mask, clr_mask, input q);
  modport bank (input ce, sw_we, sw_data, set_mask, clr_mask, output q);
endinterface : flag_bank_if

// >>> core/cause_flag_bank.sv
// One 8-bit flag register with software write and hardware set and clear
`timescale 1ns/1ps
module cause_flag_bank #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] IMPL    = 8'hff,
  parameter logic [7:0] SW_MASK = 8'hff
) (
  // Clock and reset
  input wire logic    core_clk,
  input wire logic    sys_rst,
  // Control side
  flag_bank_if.bank   fb
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  wire  [7:0] sw_base = fb.sw_we ? ((flags_q & ~SW_MASK) | (fb.sw_data & SW_MASK)) : flags_q;

  // Hardware applied after software so an event wins over a write
  assign flags_d = ((sw_base | fb.set_mask) & ~fb.clr_mask) & IMPL;
  assign fb.q    = flags_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= RST_VAL;
    end else if (fb.ce) begin
      flags_q <= flags_d;
    end
  end
endmodule // cause_flag_bank

// >>> core/cause_apb_decode.sv
// APB address decode for the recorder registers
`timescale 1ns/1ps
module cause_apb_decode
  import rcr_pkg::*;
(
  // APB request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic        ce,
  // Decoded strobes
  output logic [3:0]       rd_sel,
  output logic             wr_status,
  output logic             wr_power_control_register,
  output logic             wr_ctrl,
  output logic             pready,
  output logic             pslverr
);
  function automatic logic [3:0] reg_hit(input logic [11:0] a);
    reg_hit = {a == OFF_STATE, a == OFF_CTRL, a == OFF_POWER_CONTROL_REGISTER, a == OFF_STATUS};
  endfunction

  wire access = psel & penable & ce;
  wire [3:0] hit = reg_hit(paddr);

  // Zero wait states; a frozen block holds the bus until it runs again
  assign pready    = ce;
  assign pslverr   = access & (hit == 4'h0);
  assign rd_sel    = hit;
  assign wr_status = access & pwrite & hit[0];
  assign wr_power_control_register   = access & pwrite & hit[1];
  assign wr_ctrl   = access & pwrite & hit[2];
endmodule // cause_apb_decode

// >>> sim/reset_cause_recorder_tb.sv
// Self-checking bench for the reset cause recorder
`timescale 1ns/1ps
module reset_cause_recorder_tb
  import rcr_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        ce       = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic [6:0]  ev       = 7'h0;
  logic        pin_n    = 1'b1;
  logic        irq      = 1'b0;
  logic [14:0] cur_pc   = 15'h0000;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         pc_load;
  wire  [14:0] pc_value;
  wire         stack_push;
  wire  [14:0] push_addr;
  wire         asleep;
  wire  [3:0]  last_cause;
  int          fail_count = 0;
  int          compares   = 0;

  reset_cause_recorder DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_event(ev[0]), .bor_event(ev[1]), .external_clear_pin_n(pin_n),
    .watchdog_timer_expired(ev[2]), .interrupt_pending(irq), .sleep_instr(ev[3]),
    .reset_instr(ev[4]), .stack_overflow(ev[5]), .stack_underflow(ev[6]),
    .current_pc(cur_pc), .pc_load(pc_load), .pc_value(pc_value),
    .stack_push(stack_push), .push_addr(push_addr), .asleep(asleep),
    .last_cause(last_cause)
  );

  always #20 core_clk = ~core_clk;

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Setup then access, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, {24'h0, exp});
    chk({31'h0, e}, {31'h0, err});
  endtask

  // One-cycle source pulse; k = 7 drops the clear pin instead
  task automatic fire(input int k, input logic ld, input logic [14:0] pcv);
    int n;
    n = 0;
    @(posedge core_clk);
    if (k == 7) pin_n <= 1'b0;
    else ev[k] <= 1'b1;
    @(posedge core_clk);
    ev    <= 7'h0;
    pin_n <= 1'b1;
    #1;
    if (ld) begin
      while (pc_load !== 1'b1 && n < 5) begin
        @(posedge core_clk);
        #1;
        n++;
      end
      if (n >= 5) begin
        fail_count++;
        end_sim();
      end
      chk({17'h0, pc_value}, {17'h0, pcv});
    end else begin
      chk({31'h0, pc_load}, 32'h0);
    end
  endtask

  task automatic regs(input logic [7:0] st, input logic [7:0] pc);
    rd(OFF_STATUS, st, 1'b0);
    rd(OFF_POWER_CONTROL_REGISTER, pc, 1'b0);
  endtask

  initial begin
    #(40 * 20000);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    regs(8'h18, 8'h0c);
    rd(OFF_CTRL, 8'h00, 1'b0);
    rd(OFF_STATE, 8'h01, 1'b0);
    rd(12'h010, 8'h00, 1'b1);
    wr(OFF_POWER_CONTROL_REGISTER, 8'hff);
    wr(OFF_STATUS, 8'hff);
    regs(8'h1f, 8'hcf);
    wr(OFF_STATUS, 8'h00);
    fire(4, 1'b1, RESET_VEC);
    regs(8'h18, 8'hcb);
    fire(7, 1'b1, RESET_VEC);
    regs(8'h18, 8'hc3);
    fire(2, 1'b1, RESET_VEC);
    regs(8'h08, 8'hc3);
    fire(0, 1'b1, RESET_VEC);
    regs(8'h18, 8'h0d);
    rd(OFF_STATE, 8'h01, 1'b0);
    fire(2, 1'b1, RESET_VEC);
    wr(OFF_POWER_CONTROL_REGISTER, 8'hc3);
    fire(1, 1'b1, RESET_VEC);
    regs(8'h18, 8'h0e);
    // Frozen block takes no event and holds the bus
    @(posedge core_clk) ce <= 1'b0;
    fire(2, 1'b0, 15'h0);
    chk({31'h0, pready}, 32'h0);
    @(posedge core_clk) ce <= 1'b1;
    regs(8'h18, 8'h0e);
    // Sleep with a pending interrupt falls through
    @(posedge core_clk) irq <= 1'b1;
    fire(3, 1'b0, 15'h0);
    chk({31'h0, asleep}, 32'h0);
    regs(8'h18, 8'h0e);
    @(posedge core_clk) begin
      irq    <= 1'b0;
      cur_pc <= 15'h0100;
    end
    fire(3, 1'b0, 15'h0);
    chk({31'h0, asleep}, 32'h1);
    fire(7, 1'b1, RESET_VEC);
    chk({31'h0, asleep}, 32'h0);
    regs(8'h10, 8'h06);
    @(posedge core_clk) cur_pc <= 15'h0200;
    fire(3, 1'b0, 15'h0);
    fire(2, 1'b1, 15'h0201);
    regs(8'h00, 8'h06);
    rd(OFF_STATE, 8'h06, 1'b0);
    wr(OFF_CTRL, 8'h02);
    @(posedge core_clk) cur_pc <= 15'h0300;
    fire(3, 1'b0, 15'h0);
    @(posedge core_clk) irq <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({16'h0, pc_load, pc_value}, {16'h0, 1'b1, 15'h0301});
    chk({31'h0, asleep}, 32'h0);
    @(posedge core_clk) irq <= 1'b0;
    #1;
    chk({16'h0, pc_load, pc_value}, {16'h0, 1'b1, INT_VEC});
    chk({16'h0, stack_push, push_addr}, {16'h0, 1'b1, 15'h0302});
    chk({28'h0, last_cause}, 32'h7);
    regs(8'h10, 8'h06);
    // Without interrupts enabled the wake resumes in line, no push
    wr(OFF_CTRL, 8'h00);
    @(posedge core_clk) cur_pc <= 15'h0400;
    fire(3, 1'b0, 15'h0);
    @(posedge core_clk) irq <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({16'h0, pc_load, pc_value}, {16'h0, 1'b1, 15'h0401});
    @(posedge core_clk) irq <= 1'b0;
    #1;
    chk({30'h0, pc_load, stack_push}, 32'h0);
    wr(OFF_POWER_CONTROL_REGISTER, 8'h00);
    fire(5, 1'b0, 15'h0);
    rd(OFF_POWER_CONTROL_REGISTER, 8'h00, 1'b0);
    wr(OFF_CTRL, 8'h03);
    rd(OFF_CTRL, 8'h03, 1'b0);
    fire(5, 1'b1, RESET_VEC);
    rd(OFF_POWER_CONTROL_REGISTER, 8'h80, 1'b0);
    fire(6, 1'b1, RESET_VEC);
    rd(OFF_POWER_CONTROL_REGISTER, 8'hc0, 1'b0);
    end_sim();
  end
endmodule // reset_cause_recorder_tb
